// *** logic/usc_pkg.sv ***
package usc_pkg;

  // ****************************************
  // command codes, word framing
  // ****************************************
  localparam logic [1:0] CMD_RDATA = 2'h0;
  localparam logic [1:0] CMD_RCFG = 2'h1;
  localparam logic [1:0] CMD_WDATA = 2'h2;
  localparam logic [1:0] CMD_WCFG = 2'h3;
  localparam logic [4:0] WORD_LAST = 5'h10;
  localparam logic [4:0] CMD_KNOWN = 5'h02;
  localparam logic [3:0] OUT_FIRST = 4'hf;

  // ****************************************
  // configuration word fields
  // ****************************************
  localparam int CFG_FIFO_BYPASS = 13;
  localparam int CFG_PD_REQ = 12;
  localparam int CFG_MASK_HI = 11;
  localparam int CFG_MASK_LO = 8;
  localparam int CFG_INFRARED = 7;
  localparam int CFG_STOP2 = 6;
  localparam int CFG_PAR = 5;
  localparam int CFG_LEN7 = 4;
  localparam int CFG_DIV_HI = 3;
  localparam logic [13:0] CFG_RESET = 14'h0000;
  localparam int RC_TEST = 0;

  // mask bit order inside the four-bit mask field
  localparam int MSK_TX = 3;
  localparam int MSK_RX = 2;
  localparam int MSK_PAR = 1;
  localparam int MSK_EVT = 0;

  // data-write word fields
  localparam int DW_INHIBIT = 10;
  localparam int DW_RTS = 9;
  localparam int DW_PAR = 8;

  // ****************************************
  // receive store, timing
  // ****************************************
  localparam int RX_DEPTH = 8;
  localparam logic [3:0] RX_CAP_FIFO = 4'h8;
  localparam logic [3:0] RX_CAP_BYPASS = 4'h1;
  localparam int CLK_HZ = 250000000;
  localparam int OSC_HZ = 3686400;
  localparam logic [6:0] OSC_DIV = 7'(CLK_HZ / OSC_HZ);
  localparam logic [3:0] SUB_LAST = 4'hf;
  localparam logic [3:0] PULSE_SUBS = 4'h3;

  // ratio 1..128 for codes 0-7, 3..384 for codes 8-f
  function automatic logic [8:0] usc_ratio(input logic [3:0] code);
    return code[3] ? 9'(9'h003 << code[2:0]) : 9'(9'h001 << code[2:0]);
  endfunction

endpackage

// *** logic/usc_serial_cmd.sv ***
`timescale 1ns/1ps

// How it works
// [R1] top bits 11 issue configuration write
// [R2] config write flushes receive state, keeps handshake
// [R3] config applies at select rise when transmitter idle
// [R4] format fields wait for current transmission end
// [R5] interrupt masks act after sixteenth rising edge
// [R6] bit 13 fifo bypass, bit 12 powerdown
// [R7] mask bits 11..8 enable four interrupts
// [R8] bit 7 selects infrared timing
// [R9] bit 6 selects one or two stops
// [R10] parity enable adds bit; bit 4 seven bits
// [R11] bits 3..0 pick baud divisor
// [R12] config write answers flags plus fourteen zeros
// [R13] host waits, then verifies config by readback
// [R14] readback returns last config plus flags
// [R15] readback bit 12 shows powerdown state
// [R16] test bit: fast clock on handshake, line low
// [R17] data write sends and receives simultaneously
// [R18] transmit inhibit only updates handshake output
// [R19] receive flag clears at sixteenth falling edge
// [R20] host fetches data with all-zero word
// [R21] draining receive data clears flag and interrupt
// [R22] bit 15 receive waiting, bit 14 tx empty
// [R23] divisor table and sixteen-times generator clock
// [R24] data word: inhibit, handshake, parity, byte
// [R25] two stops only when configured
// [R26] one msb-first sixteen-bit exchange per select
// [R27] reset config: all fields zero
module usc_serial_cmd
  import usc_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic din_i,
  output logic dout_o,
  input wire logic cts_n_i,
  output logic rts_n_o,
  output logic tx_o,
  output logic irq_n_o,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_byte_i,
  input wire logic rx_parity_i,
  input wire logic rx_event_i,
  output logic baud_tick16_o,
  output logic rx_len7_o,
  output logic rx_parity_on_o,
  output logic infrared_o,
  output logic powerdown_o
);

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic sclk_s1, sclk_s2, sclk_d;
  logic cs_s1, cs_s2, cs_d;
  logic din_s1, din_s2;
  logic cts_s1, cts_s2;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      {sclk_s1, sclk_s2, sclk_d} <= 3'h0;
      {cs_s1, cs_s2, cs_d} <= 3'h7;
      {din_s1, din_s2} <= 2'h0;
      {cts_s1, cts_s2} <= 2'h3;
    end else begin
      {sclk_s1, sclk_s2, sclk_d} <= {sclk_i, sclk_s1, sclk_s2};
      {cs_s1, cs_s2, cs_d} <= {cs_n_i, cs_s1, cs_s2};
      {din_s1, din_s2} <= {din_i, din_s1};
      {cts_s1, cts_s2} <= {cts_n_i, cts_s1};
    end
  end

  wire sclk_rise = sclk_s2 & ~sclk_d & ~cs_s2;
  wire sclk_fall = ~sclk_s2 & sclk_d & ~cs_s2;
  wire cs_fall = ~cs_s2 & cs_d;
  wire cs_rise = cs_s2 & ~cs_d;

  // ****************************************
  // word shifter
  // ****************************************
  logic [4:0] bit_cnt;
  logic [15:0] in_word;
  logic [1:0] cmd_q;
  logic [3:0] out_idx;
  logic [15:0] resp;
  logic [13:0] payload;

  wire [15:0] next_in_word = {in_word[14:0], din_s2};
  wire [1:0] cmd_now = next_in_word[1:0];
  wire cmd_rise = sclk_rise & (bit_cnt == CMD_KNOWN - 5'h01);
  wire last_rise = sclk_rise & (bit_cnt == WORD_LAST - 5'h01);
  wire last_fall = sclk_fall & (bit_cnt == WORD_LAST);
  wire data_cmd = ~cmd_q[0];

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      bit_cnt <= 5'h00;
      in_word <= 16'h0000;
      cmd_q <= CMD_RDATA;
      out_idx <= OUT_FIRST;
    end else begin
      if (cs_fall) begin
        bit_cnt <= 5'h00; // [R26]
        out_idx <= OUT_FIRST;
      end else begin
        if (sclk_rise && bit_cnt != WORD_LAST) begin
          bit_cnt <= bit_cnt + 5'h01;
          in_word <= next_in_word; // [R26]
        end
        if (sclk_fall && out_idx != 4'h0) out_idx <= out_idx - 4'h1;
      end
      if (cmd_rise) cmd_q <= cmd_now;
    end
  end

  // ****************************************
  // configuration and handshake state
  // ****************************************
  logic [13:0] cfg_wr, cfg_act;
  logic cfg_req, pend_valid, t_hold, test_q;
  logic wd_req, rts_q;
  logic [15:0] wd_word;
  logic tx_busy, tbuf_full;
  logic [8:0] tbuf;

  wire wcfg_hit = last_rise & (cmd_q == CMD_WCFG);
  wire cfg_commit = cs_rise & cfg_req;
  wire wd_commit = cs_rise & wd_req;
  wire apply = pend_valid & ~tx_busy & ~cfg_commit; // [R3]
  wire pd_q = cfg_act[CFG_PD_REQ];
  wire [3:0] mask = cfg_wr[CFG_MASK_HI:CFG_MASK_LO];
  wire t_flag = ~tbuf_full & ~t_hold; // [R22]

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      cfg_wr <= CFG_RESET; // [R27]
      cfg_act <= CFG_RESET;
      cfg_req <= 1'b0;
      pend_valid <= 1'b0;
      t_hold <= 1'b0;
    end else begin
      if (wcfg_hit) cfg_wr <= next_in_word[13:0]; // [R1] [R5]
      if (wcfg_hit) cfg_req <= 1'b1;
      else if (cs_rise) cfg_req <= 1'b0;
      if (cfg_commit) begin
        pend_valid <= 1'b1;
        t_hold <= 1'b1; // [R2]
      end else if (apply) begin
        pend_valid <= 1'b0;
        t_hold <= 1'b0;
        cfg_act <= cfg_wr; // [R4]
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      test_q <= 1'b0;
      wd_req <= 1'b0;
      wd_word <= 16'h0000;
      rts_q <= 1'b0;
    end else begin
      if (last_rise && cmd_q == CMD_RCFG && next_in_word[RC_TEST]) test_q <= 1'b1; // [R16]
      else if (cs_s2) test_q <= 1'b0;
      if (last_rise && cmd_q == CMD_WDATA) begin
        wd_req <= 1'b1;
        wd_word <= next_in_word;
      end else if (cs_rise) wd_req <= 1'b0;
      if (wd_commit) rts_q <= wd_word[DW_RTS]; // [R24]
    end
  end

  // ****************************************
  // receive store
  // ****************************************
  logic [8:0] fifo_mem [RX_DEPTH];
  logic [2:0] wp, rp;
  logic [3:0] cnt;
  logic fe_q;

  wire [3:0] cap = cfg_act[CFG_FIFO_BYPASS] ? RX_CAP_BYPASS : RX_CAP_FIFO; // [R6]
  wire push = rx_valid_i & (cnt < cap) & ~pd_q;
  wire pop = last_fall & data_cmd & (cnt != 4'h0); // [R19]
  wire r_flag = (cnt != 4'h0); // [R22]
  wire [8:0] rx_head = r_flag ? fifo_mem[rp] : 9'h000;
  wire rx_b7 = rx_byte_i[7] & ~cfg_act[CFG_LEN7];

  always_ff @(posedge clk_sys_i) begin
    if (push) fifo_mem[wp] <= {rx_parity_i, rx_b7, rx_byte_i[6:0]};
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || cfg_commit) begin
      wp <= 3'h0; // [R2]
      rp <= 3'h0;
      cnt <= 4'h0;
    end else begin
      if (push) wp <= wp + 3'h1;
      if (pop) rp <= rp + 3'h1;
      cnt <= cnt + {3'h0, push} - {3'h0, pop}; // [R21]
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) fe_q <= 1'b0;
    else fe_q <= rx_event_i | (fe_q & ~(pop | cfg_commit)); // [R2]
  end

  // ****************************************
  // answer word
  // ****************************************
  always_comb begin
    unique case (cmd_now)
      CMD_RCFG: payload = {cfg_wr[13], pd_q, cfg_wr[11:0]}; // [R14] [R15]
      CMD_WDATA, CMD_RDATA: payload = {3'h0, fe_q, ~cts_s2, rx_head}; // [R17]
      CMD_WCFG: payload = 14'h0000; // [R12]
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      resp <= 16'h0000;
      dout_o <= 1'b0;
    end else begin
      if (cs_fall) resp <= {r_flag, t_flag, 14'h0000}; // [R22]
      else if (cmd_rise) resp[13:0] <= payload;
      dout_o <= cs_s2 ? 1'b0 : resp[out_idx]; // [R26]
    end
  end

  // ****************************************
  // baud generator
  // ****************************************
  logic [6:0] osc_cnt;
  logic [8:0] div_cnt;
  logic tick16;

  wire run = ~(pd_q & ~tx_busy);
  wire osc_tick = run & (osc_cnt == OSC_DIV - 7'h01);
  wire [8:0] ratio = usc_ratio(cfg_act[CFG_DIV_HI:0]); // [R11] [R23]

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      osc_cnt <= 7'h00;
      div_cnt <= 9'h000;
      tick16 <= 1'b0;
    end else begin
      if (run) osc_cnt <= osc_tick ? 7'h00 : osc_cnt + 7'h01;
      if (osc_tick) div_cnt <= (div_cnt >= ratio - 9'h001) ? 9'h000 : div_cnt + 9'h001;
      tick16 <= osc_tick & (div_cnt >= ratio - 9'h001); // [R23]
    end
  end

  // ****************************************
  // transmitter
  // ****************************************
  logic [11:0] frame;
  logic [3:0] bits_left, sub;

  wire par_on = cfg_act[CFG_PAR];
  wire len7 = cfg_act[CFG_LEN7];
  wire [2:0] tail = par_on ? {2'h3, tbuf[DW_PAR]} : 3'h7; // [R10]
  wire [11:0] next_frame = len7 ? {1'b1, tail, tbuf[6:0], 1'b0} : {tail, tbuf[7:0], 1'b0};
  wire [3:0] nbits = 4'h9 + {3'h0, ~len7} + {3'h0, par_on} + {3'h0, cfg_act[CFG_STOP2]}; // [R9] [R25]
  wire tx_start = ~tx_busy & tbuf_full & ~pend_valid & ~pd_q;
  wire bit_end = tx_busy & tick16 & (sub == SUB_LAST);

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      tbuf <= 9'h000;
      tbuf_full <= 1'b0;
    end else begin
      if (tx_start || cfg_commit) tbuf_full <= 1'b0; // [R2]
      if (cfg_commit) tbuf <= 9'h000;
      if (wd_commit && !wd_word[DW_INHIBIT]) begin // [R18]
        tbuf <= wd_word[8:0]; // [R17] [R24]
        tbuf_full <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      tx_busy <= 1'b0;
      frame <= 12'hfff;
      bits_left <= 4'h0;
      sub <= 4'h0;
    end else if (tx_start) begin
      tx_busy <= 1'b1;
      frame <= next_frame;
      bits_left <= nbits;
      sub <= 4'h0;
    end else if (tx_busy && tick16) begin
      sub <= sub + 4'h1;
      if (bit_end) begin
        frame <= {1'b1, frame[11:1]};
        bits_left <= bits_left - 4'h1;
        tx_busy <= (bits_left != 4'h1);
      end
    end
  end

  // infrared: idle low, 3/16-bit pulse for each zero bit
  wire pulse_level = tx_busy & ~frame[0] & (sub < PULSE_SUBS);
  wire uart_level = ~tx_busy | frame[0];
  wire next_tx = test_q ? 1'b0 : (cfg_act[CFG_INFRARED] ? pulse_level : uart_level); // [R8] [R16]
  wire [3:0] irq_src = {t_flag, r_flag, r_flag & rx_head[8], fe_q};

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      tx_o <= 1'b1;
      rts_n_o <= 1'b1;
      irq_n_o <= 1'b1;
    end else begin
      tx_o <= next_tx;
      rts_n_o <= test_q ? ~tick16 : ~rts_q; // [R16]
      irq_n_o <= ~|(mask & irq_src); // [R7] [R21]
    end
  end

  assign baud_tick16_o = tick16;
  assign rx_len7_o = len7;
  assign rx_parity_on_o = par_on;
  assign infrared_o = cfg_act[CFG_INFRARED];
  assign powerdown_o = pd_q;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);

  cfg_write_a: assert property (wcfg_hit |=> cfg_wr == $past(next_in_word[13:0])) // [R1]
    else $error("config word not captured");
  cfg_clear_a: assert property (cfg_commit |=> cnt == 4'h0 && !tbuf_full && !t_flag) // [R2]
    else $error("config write did not clear receive and transmit state");
  cfg_defer_a: assert property (pend_valid && tx_busy |=> pend_valid && $stable(cfg_act)) // [R3]
    else $error("config applied during transmission");
  cfg_apply_a: assert property (apply |=> !pend_valid && cfg_act == $past(cfg_wr)) // [R4]
    else $error("pending config not applied");
  mask_irq_a: assert property (mask[MSK_TX] && t_flag |=> !irq_n_o) // [R7]
    else $error("tx empty interrupt missing");
  cfg_zero_a: assert property (cmd_rise && cmd_now == CMD_WCFG |=> resp[13:0] == 14'h0000) // [R12]
    else $error("config write answer not zero");
  readback_a: assert property (cmd_rise && cmd_now == CMD_RCFG |=> resp[12] == $past(pd_q)) // [R15]
    else $error("readback powerdown bit wrong");
  test_tx_a: assert property (test_q |=> ##1 (tx_o == 1'b0) || !$past(test_q)) // [R16]
    else $error("tx not low in test mode");
  inhibit_a: assert property (wd_commit && wd_word[DW_INHIBIT] && !tbuf_full |=> !tbuf_full) // [R18]
    else $error("inhibited write started transmission");
  rflag_a: assert property (pop && cnt == 4'h1 && !push |=> !r_flag) // [R19]
    else $error("receive flag did not clear");
  stop_a: assert property (tx_start && !cfg_act[CFG_STOP2] && !par_on && !len7 |=> // [R9]
    bits_left == 4'ha)
    else $error("frame length wrong");

  cfg_write_c: cover property (cfg_commit ##[1:1000] apply);
  data_write_c: cover property (wd_commit && !wd_word[DW_INHIBIT] ##[1:300] tx_start);
  test_mode_c: cover property (test_q && tick16);
  drain_c: cover property (pop && cnt == 4'h1);

endmodule // usc_serial_cmd

// *** bench/usc_host_model.sv ***
`timescale 1ns/1ps

// ****************************************
// serial bus master in the host's place
// ****************************************
module usc_host_model (
  input wire logic clk_sys_i,
  input wire logic dout_i,
  output logic sclk_o,
  output logic cs_n_o,
  output logic din_o
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    din_o = 1'b0;
  end

  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask

  // released data line shows the inverse, not the last bit
  task automatic release_cs();
    cs_n_o <= 1'b1;
    din_o <= ~din_o;
    wt(8);
  endtask

  // one msb-first word, half period 6 clk; hold keeps select low
  task automatic xfer(input logic [15:0] w, input bit hold, output logic [15:0] r);
    cs_n_o <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      din_o <= w[i];
      wt(6);
      r[i] = dout_i;
      sclk_o <= 1'b1;
      wt(6);
      sclk_o <= 1'b0;
    end
    wt(6);
    if (!hold) begin
      release_cs();
    end
  endtask
endmodule // usc_host_model

// *** bench/usc_serial_cmd_tb.sv ***
`timescale 1ns/1ps

module usc_serial_cmd_tb;
  import usc_pkg::*;

  logic clk_sys_i;
  logic rst_n_i;
  logic sclk, cs_n, din, dout, cts_n, rts_n, tx, irq_n;
  logic rx_valid, rx_parity, rx_event, tick, len7, par_on, infra, pd;
  logic [7:0] rx_byte;
  logic [15:0] r;
  int n_errors = 0;
  int check_count = 0;
  int cyc = 0;

  usc_serial_cmd i_usc_serial_cmd (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .sclk_i(sclk), .cs_n_i(cs_n), .din_i(din), .dout_o(dout), .cts_n_i(cts_n),
    .rts_n_o(rts_n), .tx_o(tx), .irq_n_o(irq_n), .rx_valid_i(rx_valid),
    .rx_byte_i(rx_byte), .rx_parity_i(rx_parity), .rx_event_i(rx_event),
    .baud_tick16_o(tick), .rx_len7_o(len7), .rx_parity_on_o(par_on),
    .infrared_o(infra), .powerdown_o(pd));

  usc_host_model i_usc_host_model (.clk_sys_i(clk_sys_i), .dout_i(dout),
    .sclk_o(sclk), .cs_n_o(cs_n), .din_o(din));

  // ****************************************
  // clock, reporting
  // ****************************************
  initial begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("errors=%0d checks=%0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 90000) begin
      n_errors++;
      give_verdict();
    end
  end

  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask

  task automatic xf(input logic [15:0] w);
    i_usc_host_model.xfer(w, 1'b0, r);
  endtask

  task automatic push(input logic [7:0] b, input logic p, input logic ev);
    rx_byte <= b;
    rx_parity <= p;
    rx_valid <= 1'b1;
    rx_event <= ev;
    wt(1);
    rx_valid <= 1'b0;
    rx_event <= 1'b0;
    wt(1);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    xf(16'h4000);
    check(r, 16'h4000);
    check(16'({tx, rts_n, irq_n, pd}), 16'h000e);
  endtask

  task automatic t_cfg();
    logic [13:0] cf [3];
    int k;
    cf = '{14'h00b1, 14'h304e, 14'h0000};
    for (int i = 0; i < 3; i++) begin
      xf({2'b11, cf[i]});
      check(r, 16'h4000);
      xf(16'h4000);
      check(r, {2'b01, cf[i]});
      check(16'({infra, len7, par_on, pd}), 16'({cf[i][7], cf[i][4], cf[i][5], cf[i][12]}));
      check(16'(tx), 16'(!cf[i][7]));
      if (i == 0) begin
        wt(1);
        while (tick !== 1'b1) wt(1);
        k = 0;
        wt(1);
        while (tick !== 1'b1 && k < 400) begin
          wt(1);
          k++;
        end
        check(16'(k + 1), 16'(2 * OSC_DIV));
      end
    end
  endtask

  task automatic t_rx();
    push(8'h11, 1'b0, 1'b1);
    xf(16'hc400);
    check(r, 16'hc000);
    xf(16'h0000);
    check(16'(r[15:9]), 16'h0021);
    push(8'h5a, 1'b1, 1'b1);
    push(8'h3c, 1'b0, 1'b0);
    wt(2);
    check(16'(irq_n), 16'h0000);
    xf(16'h0000);
    check(r, 16'hc75a);
    xf(16'h0000);
    check(r, 16'hc23c);
    check(16'(irq_n), 16'h0001);
    cts_n <= 1'b1;
    xf(16'h0000);
    check(16'(r[15:14]), 16'h0001);
    check(r, 16'h4000);
    cts_n <= 1'b0;
  endtask

  task automatic t_tx();
    int k;
    xf(16'h8255);
    check(16'(rts_n), 16'h0000);
    k = 0;
    while (tx !== 1'b0 && k < 300) begin
      wt(1);
      k++;
    end
    k = 0;
    while (tx === 1'b0 && k < 2000) begin
      wt(1);
      k++;
    end
    check(16'(k >= 15 * OSC_DIV - 12 && k <= 16 * OSC_DIV + 2), 16'h0001);
    xf(16'hc020);
    check(16'({par_on, rts_n}), 16'h0000);
    xf(16'h4000);
    check(r, 16'h0020);
    k = 0;
    while (par_on !== 1'b1 && k < 20000) begin
      wt(1);
      k++;
    end
    check(16'({par_on, tx}), 16'h0003);
    xf(16'h4000);
    check(r, 16'h4020);
    xf(16'h8455);
    check(16'(rts_n), 16'h0001);
    k = 0;
    repeat (2000) begin
      wt(1);
      k += int'(tx !== 1'b1);
    end
    check(16'(k), 16'h0000);
  endtask

  // two frames back to back, parity on: ten low bits, then one stop bit
  task automatic t_frames();
    int k;
    int g;
    xf(16'h8200);
    xf(16'h8200);
    k = 0;
    while (tx === 1'b0 && k < 12000) begin
      wt(1);
      k++;
    end
    g = 0;
    while (tx === 1'b1 && g < 3000) begin
      wt(1);
      g++;
    end
    check(16'(k > 9 * 16 * OSC_DIV && k < 10 * 16 * OSC_DIV), 16'h0001);
    check(16'(g >= 16 * OSC_DIV - 2 && g <= 16 * OSC_DIV + 6), 16'h0001);
  endtask

  task automatic t_test();
    int nf;
    int hi;
    logic last;
    i_usc_host_model.xfer(16'h4001, 1'b1, r);
    nf = 0;
    hi = 0;
    last = rts_n;
    repeat (700) begin
      wt(1);
      nf += int'(last === 1'b1 && rts_n === 1'b0);
      hi += int'(tx !== 1'b0);
      last = rts_n;
    end
    check(16'(nf >= 9 && nf <= 11), 16'h0001);
    check(16'(hi), 16'h0000);
    i_usc_host_model.release_cs();
  endtask

  initial begin
    rst_n_i = 1'b0;
    cts_n = 1'b0;
    rx_valid = 1'b0;
    rx_byte = 8'h00;
    rx_parity = 1'b0;
    rx_event = 1'b0;
    repeat (12) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    wt(4);
    t_reset();
    t_cfg();
    t_rx();
    t_tx();
    t_frames();
    t_test();
    give_verdict();
  end
endmodule // usc_serial_cmd_tb
